/* rx_rate_match_fifo_decoder.sv */
// Receive rate match FIFO from recovered clock to local clock, then decoder.
// Assumes the word aligner drives rx_code, rx_code_valid and sync_status on rec_clk.
`timescale 1ns/100ps
`default_nettype none
`include "rm_defs.svh"
module rx_rate_match_fifo_decoder #(
    parameter int DEPTH = `RM_DEPTH,
    parameter int HALF = `RM_HALF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic rec_clk,
    input wire rm_pkg::code_t rx_code,
    input wire logic rx_code_valid,
    input wire logic sync_status,
    input wire logic rate_match_en,
    output logic [`RM_BYTE_W-1:0] rx_data,
    output logic rx_ctrl,
    output logic rx_valid,
    output logic rx_code_err,
    output logic rx_disp_err
);
    import rm_pkg::*;

    localparam ptr_t SPAN_P = ptr_t'(2 * DEPTH);
    localparam ptr_t DEPTH_P = ptr_t'(DEPTH);
    localparam ptr_t HALF_P = ptr_t'(HALF);
    // Offset that centres the used codes, so the wrap changes one gray bit
    localparam ptr_t BASE_P = ptr_t'((`RM_PTR_CODES / 2) - DEPTH);

    // Gray wrap needs an even depth inside the pointer space
    if ((DEPTH % 2) != 0 || DEPTH < 4 || DEPTH > `RM_PTR_CODES / 2
        || HALF < 1 || HALF >= DEPTH) begin : g_bad_depth
        $error("rate match depth or half level not supported");
    end

    function automatic ptr_t ptr_inc(input ptr_t p);
        return (p == SPAN_P - 6'd1) ? 6'd0 : p + 6'd1;
    endfunction

    // Words held, a minus b over two laps
    function automatic ptr_t ptr_fill(input ptr_t a, input ptr_t b);
        return a - b + ((a >= b) ? 6'd0 : SPAN_P);
    endfunction

    function automatic ptr_t to_gray(input ptr_t p);
        ptr_t v;
        v = p + BASE_P;
        return v ^ (v >> 1);
    endfunction

    function automatic ptr_t from_gray(input ptr_t g);
        ptr_t b;
        b[5] = g[5];
        for (int i = 4; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b - BASE_P;
    endfunction

    function automatic logic [4:0] slot(input ptr_t p);
        return (p >= DEPTH_P) ? 5'(p - DEPTH_P) : 5'(p);
    endfunction

    function automatic logic is_skip(input code_t c);
        return (c == `RM_SKIP_NEG) || (c == `RM_SKIP_POS);
    endfunction

    // Recovered clock side
    logic rrst_meta_reg, rec_rst_reg;
    logic en_w_meta_reg, en_w_reg;
    ptr_t rg_meta_reg, rg_sync_reg;
    ptr_t w_bin_reg, w_bin_next, w_gray_reg, w_gray_next;
    code_t mem_reg [DEPTH];
    code_t mem_next [DEPTH];
    ptr_t w_fill;
    logic drop_skip, do_write;

    // Reset, config and read pointer brought into the recovered domain
    always_ff @(posedge rec_clk) begin
        rrst_meta_reg <= sys_rst;
        rec_rst_reg <= rrst_meta_reg;
        en_w_meta_reg <= rate_match_en;
        en_w_reg <= en_w_meta_reg;
        rg_meta_reg <= r_gray_reg;
        rg_sync_reg <= rg_meta_reg;
    end

    // Write decision: drop a skip above half, never write when full
    always_comb begin
        w_fill = ptr_fill(w_bin_reg, from_gray(rg_sync_reg));
        drop_skip = rx_code_valid && is_skip(rx_code) && en_w_reg && sync_status
            && (w_fill > HALF_P);
        do_write = rx_code_valid && !drop_skip && (w_fill < DEPTH_P);
        w_bin_next = do_write ? ptr_inc(w_bin_reg) : w_bin_reg;
        w_gray_next = to_gray(w_bin_next);
        mem_next = mem_reg;
        if (do_write) begin
            mem_next[slot(w_bin_reg)] = rx_code;
        end
    end

    // Write pointer and storage
    always_ff @(posedge rec_clk) begin
        if (rec_rst_reg) begin
            w_bin_reg <= 6'd0;
            w_gray_reg <= to_gray(6'd0);
        end else begin
            w_bin_reg <= w_bin_next;
            w_gray_reg <= w_gray_next;
        end
        mem_reg <= mem_next;
    end

    // Local clock side
    ptr_t wg_meta_reg, wg_sync_reg;
    logic sync_meta_reg, sync_r_reg, en_r_meta_reg, en_r_reg;
    ptr_t r_bin_reg, r_bin_next, r_gray_reg, r_gray_next;
    code_t out_code_reg, out_code_next;
    logic out_valid_reg, out_valid_next, last_skip_reg, last_skip_next;
    ptr_t r_fill;
    rd_act_e act;

    // Write pointer, sync status and config into the local domain
    always_ff @(posedge sys_clk) begin
        wg_meta_reg <= w_gray_reg;
        wg_sync_reg <= wg_meta_reg;
        sync_meta_reg <= sync_status;
        sync_r_reg <= sync_meta_reg;
        en_r_meta_reg <= rate_match_en;
        en_r_reg <= en_r_meta_reg;
    end

    // Read decision: repeat a skip below half, else pass the next word
    always_comb begin
        r_fill = ptr_fill(from_gray(wg_sync_reg), r_bin_reg);
        if (en_r_reg && sync_r_reg && last_skip_reg && (r_fill < HALF_P)) begin
            act = RD_INSERT;
        end else if (r_fill != 6'd0) begin
            act = RD_PASS;
        end else begin
            act = RD_IDLE;
        end
        r_bin_next = r_bin_reg;
        out_code_next = out_code_reg;
        out_valid_next = 1'b0;
        last_skip_next = last_skip_reg;
        case (act)
            RD_INSERT: begin
                out_valid_next = 1'b1;
                last_skip_next = 1'b0;
            end
            RD_PASS: begin
                out_code_next = mem_reg[slot(r_bin_reg)];
                out_valid_next = 1'b1;
                last_skip_next = is_skip(mem_reg[slot(r_bin_reg)]);
                r_bin_next = ptr_inc(r_bin_reg);
            end
            default: begin
                out_valid_next = 1'b0;
            end
        endcase
        r_gray_next = to_gray(r_bin_next);
    end

    // Read pointer and staged group
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_bin_reg <= 6'd0;
            r_gray_reg <= to_gray(6'd0);
            out_code_reg <= `RM_SKIP_NEG;
            out_valid_reg <= 1'b0;
            last_skip_reg <= 1'b0;
        end else begin
            r_bin_reg <= r_bin_next;
            r_gray_reg <= r_gray_next;
            out_code_reg <= out_code_next;
            out_valid_reg <= out_valid_next;
            last_skip_reg <= last_skip_next;
        end
    end

    // Decoder behind the FIFO, always in line
    code_group_decoder u_decoder (
        .clk(sys_clk),
        .rst(sys_rst),
        .code_in(out_code_reg),
        .code_valid(out_valid_reg),
        .data_out(rx_data),
        .ctrl_out(rx_ctrl),
        .valid_out(rx_valid),
        .code_err(rx_code_err),
        .disp_err(rx_disp_err)
    );

    // Checks; write side ones also rest under the local reset, as its synced copy starts unknown
    gray_step_a: assert property (@(posedge rec_clk) disable iff (sys_rst || rec_rst_reg)
        $countones(w_gray_reg ^ $past(w_gray_reg)) <= 1)
        else $error("write gray pointer moved more than one bit");
    fill_bound_a: assert property (@(posedge rec_clk) disable iff (sys_rst || rec_rst_reg)
        w_fill <= DEPTH_P)
        else $error("write side fill above depth");
    no_overflow_a: assert property (@(posedge rec_clk) disable iff (sys_rst || rec_rst_reg)
        (w_fill == DEPTH_P) |=> (w_bin_reg == $past(w_bin_reg)))
        else $error("write taken while full");
    drop_skip_a: assert property (@(posedge rec_clk) disable iff (sys_rst || rec_rst_reg)
        (rx_code_valid && !do_write && w_fill < DEPTH_P) |-> (is_skip(rx_code)
            && sync_status && w_fill > HALF_P))
        else $error("dropped a word that was no deletable skip");
    sync_gate_a: assert property (@(posedge rec_clk) disable iff (sys_rst || rec_rst_reg)
        (rx_code_valid && !sync_status && w_fill < DEPTH_P) |=> (w_bin_reg
            == ptr_inc($past(w_bin_reg))))
        else $error("word lost before sync");
    insert_rule_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (act == RD_INSERT) |-> (last_skip_reg && is_skip(out_code_reg) && r_fill < HALF_P
            && en_r_reg))
        else $error("insertion outside the skip policy");
    insert_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (act == RD_INSERT) |=> (out_valid_reg && is_skip(out_code_reg) && act != RD_INSERT))
        else $error("skip repeated twice in a row");
    bypass_plain_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !en_r_reg |-> (act != RD_INSERT))
        else $error("skip inserted with rate matching off");
    read_ready_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (act == RD_PASS) |=> (out_valid_reg && r_bin_reg == ptr_inc($past(r_bin_reg))))
        else $error("read did not advance with valid");
endmodule
`default_nettype wire

/* rm_defs.svh */
// Constants of the receive rate match FIFO and code group decoder.
// Assumes the includer wants plain `define macros, sized where they meet logic.
`ifndef RM_DEFS_SVH
`define RM_DEFS_SVH

// Storage depth in words and the fill level that splits insert from delete
`define RM_DEPTH 20
`define RM_HALF 10
// Pointer space of 64 codes, of which two laps of the storage are used
`define RM_PTR_CODES 64
// Total clock mismatch the margin of HALF words is sized for, in ppm
`define RM_PPM_TOTAL 600
// Skip symbol code groups (abcdei fghj, a in bit 9), both disparities
`define RM_SKIP_NEG 10'h0f4
`define RM_SKIP_POS 10'h30b
// Special 6-bit sub-block that marks the K28 family
`define RM_K28_NEG 6'b001111
`define RM_K28_POS 6'b110000
// Data width of a decoded byte
`define RM_BYTE_W 8

`endif

/* rm_pkg.sv */
// Types shared by the rate match FIFO and the code group decoder.
// Assumes no other package uses these type names.
`default_nettype none
package rm_pkg;
    typedef logic [9:0] code_t;
    typedef logic [5:0] ptr_t;
    // Read side action, one-hot
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_PASS = 3'b010,
        RD_INSERT = 3'b100
    } rd_act_e;
endpackage
`default_nettype wire

/* code_group_decoder.sv */
// Code group decoder: 10-bit group to byte plus control flag, disparity tracked.
// Assumes groups arrive on clk already aligned, bit 9 carrying the first bit a.
`timescale 1ns/100ps
`default_nettype none
`include "rm_defs.svh"
module code_group_decoder (
    input wire logic clk,
    input wire logic rst,
    input wire rm_pkg::code_t code_in,
    input wire logic code_valid,
    output logic [`RM_BYTE_W-1:0] data_out,
    output logic ctrl_out,
    output logic valid_out,
    output logic code_err,
    output logic disp_err
);
    import rm_pkg::*;

    // 6b sub-block to 5 bits; bit 5 flags a legal group
    function automatic logic [5:0] dec6(input logic [5:0] s);
        case (s)
            6'b100111, 6'b011000: dec6 = 6'h20; 6'b011101, 6'b100010: dec6 = 6'h21;
            6'b101101, 6'b010010: dec6 = 6'h22; 6'b110001: dec6 = 6'h23;
            6'b110101, 6'b001010: dec6 = 6'h24; 6'b101001: dec6 = 6'h25;
            6'b011001: dec6 = 6'h26; 6'b111000, 6'b000111: dec6 = 6'h27;
            6'b111001, 6'b000110: dec6 = 6'h28; 6'b100101: dec6 = 6'h29;
            6'b010101: dec6 = 6'h2a; 6'b110100: dec6 = 6'h2b;
            6'b001101: dec6 = 6'h2c; 6'b101100: dec6 = 6'h2d;
            6'b011100: dec6 = 6'h2e; 6'b010111, 6'b101000: dec6 = 6'h2f;
            6'b011011, 6'b100100: dec6 = 6'h30; 6'b100011: dec6 = 6'h31;
            6'b010011: dec6 = 6'h32; 6'b110010: dec6 = 6'h33;
            6'b001011: dec6 = 6'h34; 6'b101010: dec6 = 6'h35;
            6'b011010: dec6 = 6'h36; 6'b111010, 6'b000101: dec6 = 6'h37;
            6'b110011, 6'b001100: dec6 = 6'h38; 6'b100110: dec6 = 6'h39;
            6'b010110: dec6 = 6'h3a; 6'b110110, 6'b001001: dec6 = 6'h3b;
            6'b001110, 6'b001111, 6'b110000: dec6 = 6'h3c;
            6'b101110, 6'b010001: dec6 = 6'h3d; 6'b011110, 6'b100001: dec6 = 6'h3e;
            6'b101011, 6'b010100: dec6 = 6'h3f;
            default: dec6 = 6'h00;
        endcase
    endfunction

    // 4b sub-block to 3 bits; bit 3 flags a legal group
    function automatic logic [3:0] dec4(input logic [3:0] f);
        case (f)
            4'b1011, 4'b0100: dec4 = 4'h8; 4'b1001: dec4 = 4'h9;
            4'b0101: dec4 = 4'ha; 4'b1100, 4'b0011: dec4 = 4'hb;
            4'b1101, 4'b0010: dec4 = 4'hc; 4'b1010: dec4 = 4'hd;
            4'b0110: dec4 = 4'he; 4'b1110, 4'b0001, 4'b0111, 4'b1000: dec4 = 4'hf;
            default: dec4 = 4'h0;
        endcase
    endfunction

    // Checks one sub-block against running disparity; returns {err, new rd}
    function automatic logic [1:0] disp_step(input logic rd, input int ones, input int bal);
        if (ones > bal) begin
            disp_step = {rd, 1'b1};
        end else if (ones < bal) begin
            disp_step = {~rd, 1'b0};
        end else begin
            disp_step = {1'b0, rd};
        end
    endfunction

    logic rd_reg, rd_next;
    logic [`RM_BYTE_W-1:0] data_reg, data_next;
    logic ctrl_reg, ctrl_next, valid_reg, valid_next;
    logic cerr_reg, cerr_next, derr_reg, derr_next;

    // Decode one group per valid cycle and carry running disparity
    always_comb begin
        logic [5:0] six;
        logic [3:0] four;
        logic [5:0] d6;
        logic [3:0] d4;
        logic [1:0] s1;
        logic [1:0] s2;
        logic k28;
        six = code_in[9:4];
        four = code_in[3:0];
        k28 = (six == `RM_K28_NEG) || (six == `RM_K28_POS);
        d6 = dec6(six);
        d4 = dec4((six == `RM_K28_POS) ? ~four : four);
        s1 = disp_step(rd_reg, $countones(six), 3);
        s2 = disp_step(s1[0], $countones(four), 2);
        rd_next = rd_reg;
        data_next = data_reg;
        ctrl_next = ctrl_reg;
        cerr_next = cerr_reg;
        derr_next = derr_reg;
        valid_next = code_valid;
        if (code_valid) begin
            data_next = {d4[2:0], d6[4:0]};
            ctrl_next = k28 || (((four == 4'b0111) || (four == 4'b1000))
                && ((d6[4:0] == 5'd23) || (d6[4:0] == 5'd27)
                || (d6[4:0] == 5'd29) || (d6[4:0] == 5'd30)));
            cerr_next = ~d6[5] | ~d4[3];
            derr_next = s1[1] | s2[1];
            rd_next = s2[0];
        end
    end

    // Output and disparity registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_reg <= 1'b0;
            data_reg <= '0;
            ctrl_reg <= 1'b0;
            valid_reg <= 1'b0;
            cerr_reg <= 1'b0;
            derr_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            data_reg <= data_next;
            ctrl_reg <= ctrl_next;
            valid_reg <= valid_next;
            cerr_reg <= cerr_next;
            derr_reg <= derr_next;
        end
    end

    assign data_out = data_reg;
    assign ctrl_out = ctrl_reg;
    assign valid_out = valid_reg;
    assign code_err = cerr_reg;
    assign disp_err = derr_reg;

    // Skip group must come out as control byte 0x1c
    skip_decode_a: assert property (@(posedge clk) disable iff (rst)
        (code_valid && (code_in == `RM_SKIP_NEG)) |=> (ctrl_out && data_out == 8'h1c
            && !code_err))
        else $error("skip group not decoded as control 0x1c");
    // One output per input group, one cycle later
    dec_valid_a: assert property (@(posedge clk) disable iff (rst)
        valid_out == $past(code_valid))
        else $error("decoder valid does not follow input");
endmodule
`default_nettype wire

/* rx_aligner_model.sv */
// Word aligner stand-in feeding aligned code groups on the recovered clock.
// Assumes the bench queues groups through send and steers sync with sync_req.
`timescale 1ns/100ps
`default_nettype none
module rx_aligner_model (
    input wire logic rec_clk,
    input wire logic rst,
    input wire logic sync_req,
    input wire logic gap_mode,
    output rm_pkg::code_t rx_code,
    output logic rx_code_valid,
    output logic sync_status
);
    import rm_pkg::*;
    code_t pend_q[$];
    logic gap_reg;

    // Queue one group for sending
    task automatic send(input code_t c);
        pend_q.push_back(c);
    endtask

    // Quiet line at time zero
    initial begin
        rx_code = 10'h155;
        rx_code_valid = 1'b0;
        sync_status = 1'b0;
        gap_reg = 1'b0;
    end

    // One group a cycle, or every other cycle when slow
    always @(posedge rec_clk) begin
        if (rst || pend_q.size() == 0 || (gap_mode && !gap_reg)) begin
            rx_code_valid <= 1'b0;
            rx_code <= ~rx_code; // No stale group left on the bus
        end else begin
            rx_code <= pend_q.pop_front();
            rx_code_valid <= 1'b1;
        end
        gap_reg <= gap_mode ? ~gap_reg : 1'b1;
        sync_status <= sync_req && !rst;
    end
endmodule
`default_nettype wire

/* tb_rx_rate_match_fifo_decoder.sv */
// Directed bench for the receive rate match FIFO and decoder.
// Assumes rx_aligner_model drives the recovered clock side.
`timescale 1ns/100ps
`default_nettype none
`include "rm_defs.svh"
module tb_rx_rate_match_fifo_decoder;
    import rm_pkg::*;
    localparam code_t D00 = 10'h274;
    localparam code_t D215 = 10'h2aa;
    localparam code_t D102 = 10'h155;
    localparam code_t SKP = `RM_SKIP_NEG;
    localparam logic [10:0] E_D00 = 11'h000;
    localparam logic [10:0] E_D215 = 11'h0b5;
    localparam logic [10:0] E_D102 = 11'h04a;
    localparam logic [10:0] E_SKP = 11'h11c;
    localparam logic [10:0] ALL = 11'h7ff;
    logic sys_clk, sys_rst, rec_clk, rate_match_en, sync_req, gap_mode;
    code_t rx_code;
    logic rx_code_valid, sync_status, rx_ctrl, rx_valid, rx_code_err, rx_disp_err;
    logic [`RM_BYTE_W-1:0] rx_data;
    int n_errors = 0;
    int num_checks = 0;
    logic [10:0] seen_q[$];
    code_t seq_q[$] = '{D00, SKP, SKP, D215, D102, SKP, D00};
    logic [10:0] plain_q[$] = '{E_D00, E_SKP, E_SKP, E_D215, E_D102, E_SKP, E_D00};
    logic [10:0] ins_q[$] = '{E_D00, E_SKP, E_SKP, E_SKP, E_SKP, E_D215, E_D102,
        E_SKP, E_SKP, E_D00};

    rx_aligner_model u_model (.rec_clk(rec_clk), .rst(sys_rst), .sync_req(sync_req),
        .gap_mode(gap_mode), .rx_code(rx_code), .rx_code_valid(rx_code_valid),
        .sync_status(sync_status));

    rx_rate_match_fifo_decoder #(.DEPTH(`RM_DEPTH), .HALF(`RM_HALF)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .rec_clk(rec_clk), .rx_code(rx_code),
        .rx_code_valid(rx_code_valid), .sync_status(sync_status),
        .rate_match_en(rate_match_en), .rx_data(rx_data), .rx_ctrl(rx_ctrl),
        .rx_valid(rx_valid), .rx_code_err(rx_code_err), .rx_disp_err(rx_disp_err));

    // Local clock and reset state at time zero
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        rate_match_en = 1'b0;
        sync_req = 1'b0;
        gap_mode = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Recovered clock, offset in phase from the local clock
    initial begin
        rec_clk = 1'b0;
        #3.7;
        forever #32 rec_clk = ~rec_clk;
    end

    // Collect every decoded group mid-cycle, clear of the launching edge
    always @(negedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            seen_q.push_back({rx_code_err, rx_disp_err, rx_ctrl, rx_data});
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Send groups, wait for the output stream, compare it in order
    task automatic run(input code_t codes[$], input logic [10:0] exp[$],
        input logic [10:0] mask);
        int i;
        seen_q.delete();
        foreach (codes[k]) begin
            u_model.send(codes[k]);
        end
        for (i = 0; i < 2000 && seen_q.size() < exp.size(); i++) begin
            @(posedge sys_clk);
        end
        if (i == 2000) begin
            check(32'h0, 32'h1, "output wait ran out");
            wrap_up();
        end
        repeat (200) @(posedge sys_clk);
        check(seen_q.size(), exp.size(), "group count");
        foreach (exp[k]) begin
            check({21'h0, seen_q[k] & mask}, {21'h0, exp[k] & mask}, "decoded group");
        end
    endtask

    // Set config and aligner sync, then let both cross
    task automatic set_mode(input logic en, input logic sync, input logic gap);
        @(posedge sys_clk);
        rate_match_en <= en;
        sync_req <= sync;
        gap_mode <= gap;
        repeat (8) @(posedge rec_clk);
        @(posedge sys_clk);
    endtask

    // Reset long enough for both clocks, outputs checked quiet in reset and two cycles after release
    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (4) @(posedge rec_clk);
        @(posedge sys_clk);
        check({rx_valid, rx_code_err, rx_disp_err, rx_ctrl, rx_data}, 32'h0, "reset outputs");
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check({rx_valid, rx_code_err, rx_disp_err, rx_ctrl, rx_data}, 32'h0, "release outputs");
        repeat (5) @(posedge rec_clk);
        $display("test reset done");
    endtask

    task automatic test_bypass();
        set_mode(1'b0, 1'b1, 1'b0);
        run(seq_q, plain_q, ALL);
        $display("test bypass done");
    endtask

    task automatic test_presync();
        set_mode(1'b1, 1'b0, 1'b1);
        run(seq_q, plain_q, ALL);
        $display("test presync done");
    endtask

    task automatic test_insert();
        set_mode(1'b1, 1'b1, 1'b0);
        run(seq_q, ins_q, ALL);
        $display("test insert done");
    endtask

    task automatic test_errors();
        set_mode(1'b0, 1'b1, 1'b0);
        run('{`RM_SKIP_POS}, '{11'h31c}, ALL);
        run('{10'h000}, '{11'h400}, 11'h400);
        do_reset();
        $display("test errors done");
    endtask

    // Main sequence
    initial begin
        @(posedge sys_clk);
        do_reset();
        test_bypass();
        test_presync();
        test_insert();
        test_errors();
        wrap_up();
    end
endmodule
`default_nettype wire
